// ### sfc_params.svh
/*
 * Constants of the synthesizer fastlock and counter-control block: the
 * serial word layout, the reset values, the time-out modes and timing.
 * Assumes it is included by the package and the modules by its bare name.
 */
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// ********************************************************************
// Serial word layout
// ********************************************************************
`define SFC_WORD_W 24
`define SFC_ADDR_W 4
`define SFC_ADDR_FASTLOCK 4'hD
`define SFC_ADDR_TEST 4'hF
`define SFC_TOC_LSB 4
`define SFC_TOC_W 14
`define SFC_CPF_LSB 18
`define SFC_CPF_W 4
`define SFC_CSR_LSB 22
`define SFC_CSR_W 2
`define SFC_QUARTER_BIT 13
`define SFC_IF_RST_BIT 7
`define SFC_RF_COUNTER_RESET_BIT_BIT 6
`define SFC_IF_FLOAT_BIT 5
`define SFC_RF_FLOAT_BIT 4
`define SFC_DEN_LO_W 12
`define SFC_DEN_HI_W 10

// ********************************************************************
// Reset values and time-out modes
// ********************************************************************
`define SFC_TOC_RST 14'h0000
`define SFC_CPF_RST 4'h0
`define SFC_CSR_RST 2'h0
`define SFC_BIT_RST 1'b0
`define SFC_TOC_FLOAT 14'h0000
`define SFC_TOC_MANUAL 14'h0001
`define SFC_TOC_LOW 14'h0002
`define SFC_TOC_HIGH 14'h0003
`define SFC_TOC_AUTO_MIN 14'h0004

// ********************************************************************
// Timing
// ********************************************************************
`define SFC_SYS_CLK_MHZ 50
`define SFC_PWR_RST_NS 100
`define SFC_PWR_RST_CYC ((`SFC_PWR_RST_NS * `SFC_SYS_CLK_MHZ + 999) / 1000)

`endif

// ### sfc_pkg.sv
/*
 * Types of the synthesizer fastlock and counter-control block.
 * Assumes sfc_params.svh is on the include path.
 */
`include "sfc_params.svh"

package sfc_pkg;

  // ******************************************************************
  // Register images and carriers
  // ******************************************************************
  typedef struct packed {
    logic [`SFC_CSR_W-1:0] cycle_slip_reduce_field;
    logic [`SFC_CPF_W-1:0] rf_fastlock_pump_current;
    logic [`SFC_TOC_W-1:0] rf_fastlock_timeout_count;
  } sfc_fastlock_reg_t;

  typedef struct packed {
    logic lock_detect_quarter_rate;
    logic if_counter_reset_bit;
    logic rf_counter_reset_bit;
    logic if_pump_float_field;
    logic rf_pump_float_field;
  } sfc_test_reg_t;

  typedef struct packed {
    logic rf_counter_hold;
    logic rf_pump_hiz;
    logic if_counter_hold;
    logic if_pump_hiz;
  } sfc_pump_ctl_t;

  typedef enum logic {SFC_FT_IDLE, SFC_FT_RUN} sfc_ft_state_t;

  typedef struct packed {
    logic [`SFC_WORD_W-1:0] shift;
  } sfc_link_st_t;

  typedef struct packed {
    logic [2:0][2:0] sync;
    logic [2:0] lvl;
    sfc_fastlock_reg_t fl_reg;
    sfc_test_reg_t test_reg;
    logic [`SFC_DEN_HI_W+`SFC_DEN_LO_W-1:0] den;
    logic [1:0] quarter_cnt;
    logic ld_rf;
    logic ld_if;
    logic [3:0] pwr_cnt;
    logic pin_o;
    logic pin_oe_n;
    logic fl_act;
    logic [4:0] pump_mult;
    logic [2:0] csr_shift;
    sfc_pump_ctl_t pump_ctl;
  } sfc_ctrl_st_t;

endpackage : sfc_pkg

// ### sfc_link_shifter.sv
/*
 * Serial shifter on the link clock: one bit per rising edge, first bit
 * ends up in bit 23. Assumes the host stops the link clock before the
 * latch strobe rises and keeps it still until the strobe has fallen.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sfc_params.svh"

module sfc_link_shifter (
  input wire logic sclk_link,
  input wire logic serial_data,
  output logic [`SFC_WORD_W-1:0] link_word
);
  import sfc_pkg::*;

  sfc_link_st_t st_r;
  sfc_link_st_t st_nxt;

  // Shift in, most significant bit first; no reset since clock may stop
  always_comb begin
    st_nxt = st_r;
    st_nxt.shift = {st_r.shift[`SFC_WORD_W-2:0], serial_data};
  end

  // Link-domain state
  always_ff @(posedge sclk_link) begin
    st_r <= st_nxt;
  end

  assign link_word = st_r.shift;

endmodule : sfc_link_shifter

`default_nettype wire

// ### sfc_fastlock_timer.sv
/*
 * Fastlock time-out timer: holds fastlock for twice the time-out count in
 * comparison events. Assumes start and cmp_evt are one-cycle pulses on
 * sys_clk and timeout_count comes from a register on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sfc_params.svh"

module sfc_fastlock_timer #(
  parameter int TOC_W = `SFC_TOC_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic cmp_evt,
  input wire logic [TOC_W-1:0] timeout_count,
  output logic active
);
  import sfc_pkg::*;

  typedef struct packed {
    sfc_ft_state_t state;
    logic [TOC_W:0] evt_cnt;
  } sfc_ft_st_t;

  localparam sfc_ft_st_t ST_RST = '{state: SFC_FT_IDLE, default: '0};

  sfc_ft_st_t st_r;
  sfc_ft_st_t st_nxt;
  logic auto_en;
  logic [TOC_W:0] hold_len;
  logic [TOC_W:0] cnt_inc;

  generate
    if (TOC_W < 3 || TOC_W > 30) begin : g_bad_width
      $error("sfc_fastlock_timer: TOC_W out of range");
    end
  endgenerate

  // Automatic mode and hold length of two events per count
  assign auto_en = timeout_count >= TOC_W'(`SFC_TOC_AUTO_MIN);
  assign hold_len = {timeout_count, 1'b0};
  assign cnt_inc = st_r.evt_cnt + 1'b1;

  // Idle / run sequencing
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      SFC_FT_IDLE: begin
        if (start && auto_en) begin
          st_nxt.state = SFC_FT_RUN;
          st_nxt.evt_cnt = '0;
        end
      end
      SFC_FT_RUN: begin
        if (!auto_en) begin
          st_nxt.state = SFC_FT_IDLE;
        end else if (start) begin
          st_nxt.evt_cnt = '0;
        end else if (cmp_evt) begin
          st_nxt.evt_cnt = cnt_inc;
          if (cnt_inc >= hold_len) begin
            st_nxt.state = SFC_FT_IDLE;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.state == SFC_FT_RUN;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  AST_FL_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start && auto_en |=> st_r.state == SFC_FT_RUN)
    else $error("fastlock did not start");

  AST_FL_HOLD_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.state == SFC_FT_RUN && auto_en && !start && cmp_evt &&
    cnt_inc >= hold_len |=> st_r.state == SFC_FT_IDLE)
    else $error("fastlock outlived its time-out");

  AST_FL_NO_EARLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.state == SFC_FT_RUN && auto_en &&
    !(cmp_evt && cnt_inc >= hold_len) |=> st_r.state == SFC_FT_RUN)
    else $error("fastlock ended early");

endmodule : sfc_fastlock_timer

`default_nettype wire

// ### sfc_counter_ctrl.sv
/*
 * Fastlock and counter-control register bank of a fractional-N
 * synthesizer, loaded by 24-bit serial words. Assumes the host stops the
 * link clock before raising the latch strobe, and that the denominator
 * halves, width select, frequency-word strobe and power-up pulse come
 * from logic on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sfc_params.svh"

module sfc_counter_ctrl #(
  parameter int TOC_W = `SFC_TOC_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk_link,
  input wire logic serial_data,
  input wire logic latch_en,
  input wire logic rf_cmp_pin,
  input wire logic if_cmp_pin,
  input wire logic freq_word_strobe,
  input wire logic power_up_pulse,
  input wire logic wide_fraction_sel,
  input wire logic [`SFC_DEN_LO_W-1:0] den_low,
  input wire logic [`SFC_DEN_HI_W-1:0] den_high,
  output logic [`SFC_DEN_HI_W+`SFC_DEN_LO_W-1:0] rf_fraction_denominator,
  output logic rf_fastlock_pin_o,
  output logic rf_fastlock_pin_oe_n,
  output logic fastlock_active,
  output logic [4:0] rf_pump_mult,
  output logic [2:0] cycle_slip_shift,
  output logic ld_rf_tick,
  output logic ld_if_tick,
  output sfc_pkg::sfc_pump_ctl_t pump_ctl
);
  import sfc_pkg::*;

  localparam int LE_IDX = 0;
  localparam int RF_IDX = 1;
  localparam int IF_IDX = 2;
  localparam sfc_ctrl_st_t ST_RST = '{
    fl_reg: '{`SFC_CSR_RST, `SFC_CPF_RST, `SFC_TOC_RST},
    test_reg: '{default: `SFC_BIT_RST},
    pin_oe_n: 1'b1,
    pwr_cnt: 4'(`SFC_PWR_RST_CYC),
    pump_ctl: '{default: 1'b1},
    default: '0
  };

  sfc_ctrl_st_t st_r;
  sfc_ctrl_st_t st_nxt;
  logic [`SFC_WORD_W-1:0] link_word;
  logic [2:0] pin_vec;
  logic [2:0] rise;
  logic timer_act;
  logic auto_rst;
  logic [`SFC_TOC_W-1:0] word_toc;
  logic [`SFC_ADDR_W-1:0] word_addr;

  generate
    if (TOC_W != `SFC_TOC_W) begin : g_bad_toc
      $error("sfc_counter_ctrl: TOC_W must match the word layout");
    end
    if (`SFC_PWR_RST_CYC < 1 || `SFC_PWR_RST_CYC > 15) begin : g_bad_pwr
      $error("sfc_counter_ctrl: power-up reset count out of range");
    end
  endgenerate

  // ******************************************************************
  // Helpers
  // ******************************************************************

  // Accept a new level once second and third flops agree
  function automatic logic settle(input logic [1:0] late,
                                  input logic held);
    settle = (late[0] == late[1]) ? late[1] : held;
  endfunction : settle

  // ******************************************************************
  // Link side and fastlock timer
  // ******************************************************************

  // Shift register on the link's own clock
  sfc_link_shifter i_sfc_link_shifter (
    .sclk_link(sclk_link),
    .serial_data(serial_data),
    .link_word(link_word)
  );

  // Fastlock hold timer counting RF comparison events
  sfc_fastlock_timer #(
    .TOC_W(TOC_W)
  ) i_sfc_fastlock_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(freq_word_strobe),
    .cmp_evt(rise[RF_IDX]),
    .timeout_count(st_r.fl_reg.rf_fastlock_timeout_count),
    .active(timer_act)
  );

  // Pins that cross into sys_clk
  assign pin_vec = {if_cmp_pin, rf_cmp_pin, latch_en};
  assign word_addr = link_word[`SFC_ADDR_W-1:0];
  assign word_toc = link_word[`SFC_TOC_LSB +: `SFC_TOC_W];

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    st_nxt = st_r;
    rise = '0;
    auto_rst = 1'b0;

    // Three-flop synchronisers with agreement filter
    for (int i = 0; i < 3; i++) begin
      st_nxt.sync[i] = {st_r.sync[i][1:0], pin_vec[i]};
      st_nxt.lvl[i] = settle(st_r.sync[i][2:1], st_r.lvl[i]);
      rise[i] = st_nxt.lvl[i] & ~st_r.lvl[i];
    end

    // Word routing on the latch strobe; the link word is still here
    if (rise[LE_IDX]) begin
      if (word_addr == `SFC_ADDR_FASTLOCK) begin
        st_nxt.fl_reg.cycle_slip_reduce_field =
          link_word[`SFC_CSR_LSB +: `SFC_CSR_W];
        st_nxt.fl_reg.rf_fastlock_pump_current =
          link_word[`SFC_CPF_LSB +: `SFC_CPF_W];
        st_nxt.fl_reg.rf_fastlock_timeout_count = word_toc;
      end else if (word_addr == `SFC_ADDR_TEST) begin
        st_nxt.test_reg.lock_detect_quarter_rate =
          link_word[`SFC_QUARTER_BIT];
        st_nxt.test_reg.if_counter_reset_bit = link_word[`SFC_IF_RST_BIT];
        st_nxt.test_reg.rf_counter_reset_bit = link_word[`SFC_RF_COUNTER_RESET_BIT_BIT];
        st_nxt.test_reg.if_pump_float_field = link_word[`SFC_IF_FLOAT_BIT];
        st_nxt.test_reg.rf_pump_float_field = link_word[`SFC_RF_FLOAT_BIT];
      end
    end

    // Denominator width select
    if (wide_fraction_sel) begin
      st_nxt.den = {den_high, den_low};
    end else begin
      st_nxt.den = {{`SFC_DEN_HI_W{1'b0}}, den_low};
    end

    // Fastlock state; a timer still running on an old count is masked
    st_nxt.fl_act = (timer_act && st_nxt.fl_reg.rf_fastlock_timeout_count >=
      `SFC_TOC_AUTO_MIN) ||
      st_nxt.fl_reg.rf_fastlock_timeout_count == `SFC_TOC_MANUAL;

    // Fastlock pin function from the time-out count
    st_nxt.pin_oe_n = 1'b0;
    unique case (st_nxt.fl_reg.rf_fastlock_timeout_count)
      `SFC_TOC_FLOAT: begin
        st_nxt.pin_o = 1'b0;
        st_nxt.pin_oe_n = 1'b1;
      end
      `SFC_TOC_MANUAL: st_nxt.pin_o = 1'b0;
      `SFC_TOC_LOW: st_nxt.pin_o = 1'b0;
      `SFC_TOC_HIGH: st_nxt.pin_o = 1'b1;
      default: st_nxt.pin_o = timer_act;
    endcase

    // Fastlock pump current in base steps, zero means steady setting
    if (st_nxt.fl_act) begin
      st_nxt.pump_mult =
        {1'b0, st_nxt.fl_reg.rf_fastlock_pump_current} + 5'h01;
    end else begin
      st_nxt.pump_mult = 5'h00;
    end

    // Slip reduction as a right shift of the sample rate
    unique case (st_nxt.fl_reg.cycle_slip_reduce_field)
      2'h0: st_nxt.csr_shift = 3'h0;
      2'h1: st_nxt.csr_shift = 3'h1;
      2'h2: st_nxt.csr_shift = 3'h2;
      2'h3: st_nxt.csr_shift = 3'h4;
    endcase

    // Lock-detect event feed, RF optionally divided by four
    st_nxt.ld_if = rise[IF_IDX];
    st_nxt.ld_rf = 1'b0;
    if (!st_r.test_reg.lock_detect_quarter_rate) begin
      st_nxt.quarter_cnt = 2'h0;
      st_nxt.ld_rf = rise[RF_IDX];
    end else if (rise[RF_IDX]) begin
      st_nxt.quarter_cnt = st_r.quarter_cnt + 2'h1;
      st_nxt.ld_rf = st_r.quarter_cnt == 2'h3;
    end

    // Automatic counter reset after each power-up
    if (power_up_pulse) begin
      st_nxt.pwr_cnt = 4'(`SFC_PWR_RST_CYC);
    end else if (st_r.pwr_cnt != 4'h0) begin
      st_nxt.pwr_cnt = st_r.pwr_cnt - 4'h1;
    end
    auto_rst = st_nxt.pwr_cnt != 4'h0;

    // Counter holds and pump floats
    st_nxt.pump_ctl.rf_counter_hold =
      st_nxt.test_reg.rf_counter_reset_bit | auto_rst;
    st_nxt.pump_ctl.rf_pump_hiz = st_nxt.test_reg.rf_counter_reset_bit |
      st_nxt.test_reg.rf_pump_float_field | auto_rst;
    st_nxt.pump_ctl.if_counter_hold =
      st_nxt.test_reg.if_counter_reset_bit | auto_rst;
    st_nxt.pump_ctl.if_pump_hiz = st_nxt.test_reg.if_counter_reset_bit |
      st_nxt.test_reg.if_pump_float_field | auto_rst;
  end

  // ******************************************************************
  // State register and outputs
  // ******************************************************************

  // Single state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign rf_fraction_denominator = st_r.den;
  assign rf_fastlock_pin_o = st_r.pin_o;
  assign rf_fastlock_pin_oe_n = st_r.pin_oe_n;
  assign fastlock_active = st_r.fl_act;
  assign rf_pump_mult = st_r.pump_mult;
  assign cycle_slip_shift = st_r.csr_shift;
  assign ld_rf_tick = st_r.ld_rf;
  assign ld_if_tick = st_r.ld_if;
  assign pump_ctl = st_r.pump_ctl;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_DEN_NARROW: assert property (
    !wide_fraction_sel |=> rf_fraction_denominator ==
      {{`SFC_DEN_HI_W{1'b0}}, $past(den_low)})
    else $error("narrow denominator wrong");

  AST_DEN_WIDE: assert property (
    wide_fraction_sel |=> rf_fraction_denominator ==
      {$past(den_high), $past(den_low)})
    else $error("wide denominator wrong");

  AST_GPO_NO_TIMER: assert property (
    st_r.fl_reg.rf_fastlock_timeout_count < `SFC_TOC_AUTO_MIN
    |=> !timer_act)
    else $error("timer ran with time-out below four");

  AST_AUTO_PIN: assert property (
    st_r.fl_reg.rf_fastlock_timeout_count >= `SFC_TOC_AUTO_MIN &&
    $stable(st_r.fl_reg) |-> !rf_fastlock_pin_oe_n &&
    rf_fastlock_pin_o == $past(timer_act))
    else $error("fastlock pin not following fastlock");

  AST_PIN_FLOAT: assert property (
    st_r.fl_reg.rf_fastlock_timeout_count == `SFC_TOC_FLOAT
    |-> rf_fastlock_pin_oe_n && !fastlock_active)
    else $error("pin not floating");

  AST_PIN_MANUAL: assert property (
    st_r.fl_reg.rf_fastlock_timeout_count == `SFC_TOC_MANUAL
    |-> !rf_fastlock_pin_oe_n && !rf_fastlock_pin_o && fastlock_active)
    else $error("manual fastlock not forced");

  AST_PIN_LEVELS: assert property (
    st_r.fl_reg.rf_fastlock_timeout_count == `SFC_TOC_HIGH
    |-> !rf_fastlock_pin_oe_n && rf_fastlock_pin_o)
    else $error("pin not high");

  AST_PUMP_MULT: assert property (
    fastlock_active |-> rf_pump_mult ==
      {1'b0, st_r.fl_reg.rf_fastlock_pump_current} + 5'h01)
    else $error("fastlock pump current wrong");

  AST_CSR_SIXTEENTH: assert property (
    st_r.fl_reg.cycle_slip_reduce_field == 2'h3 |-> cycle_slip_shift == 3'h4)
    else $error("slip reduction factor wrong");

  AST_QUARTER: assert property (
    st_r.test_reg.lock_detect_quarter_rate && rise[RF_IDX] &&
    st_r.quarter_cnt != 2'h3 |=> !ld_rf_tick)
    else $error("RF lock-detect event not divided");

  AST_IF_HOLD: assert property (
    st_r.test_reg.if_counter_reset_bit
    |-> pump_ctl.if_counter_hold && pump_ctl.if_pump_hiz)
    else $error("IF reset not applied");

  AST_RF_HOLD: assert property (
    st_r.test_reg.rf_counter_reset_bit
    |-> pump_ctl.rf_counter_hold && pump_ctl.rf_pump_hiz)
    else $error("RF reset not applied");

  AST_PWR_UP: assert property (
    power_up_pulse |=> (pump_ctl.rf_counter_hold &&
      pump_ctl.if_counter_hold)[*5])
    else $error("power-up counter reset too short");

  AST_RF_FLOAT_ONLY: assert property (
    st_r.test_reg.rf_pump_float_field &&
    !st_r.test_reg.rf_counter_reset_bit && st_r.pwr_cnt == 4'h0
    |-> pump_ctl.rf_pump_hiz && !pump_ctl.rf_counter_hold)
    else $error("RF float touched counters");

  AST_WORD_ROUTE: assert property (
    rise[LE_IDX] && word_addr == `SFC_ADDR_FASTLOCK
    |=> st_r.fl_reg.rf_fastlock_timeout_count == $past(word_toc))
    else $error("fastlock word not stored");

  COV_AUTO_FASTLOCK: cover property (
    freq_word_strobe && st_r.fl_reg.rf_fastlock_timeout_count ==
      `SFC_TOC_AUTO_MIN ##[1:200] $fell(fastlock_active));
  COV_TEST_WORD: cover property (
    rise[LE_IDX] && word_addr == `SFC_ADDR_TEST);
  COV_QUARTER_TICK: cover property (
    st_r.test_reg.lock_detect_quarter_rate && ld_rf_tick);

endmodule : sfc_counter_ctrl

`default_nettype wire

// ### sfc_host_model.sv
/*
 * Host model: shifts 24-bit words on its own link clock and raises the
 * latch strobe. Assumes the bench calls send_word one word at a time.
 */
`timescale 1ns/10ps
`default_nettype none

module sfc_host_model (
  output logic sclk_link,
  output logic serial_data,
  output logic latch_en
);
  // Idle link: clock still, latch low
  initial begin
    sclk_link = 1'b0;
    serial_data = 1'b0;
    latch_en = 1'b0;
  end

  // *****************************************************************
  // Word transfer, 32 ns link period, latch held 120 ns
  // *****************************************************************
  task automatic send_word(input logic [23:0] w);
    #7;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #16 sclk_link = 1'b1;
      #16 sclk_link = 1'b0;
    end
    serial_data = ~w[0]; // Released line shows no stale bit
    #16 latch_en = 1'b1;
    #120 latch_en = 1'b0;
    #120;
  endtask : send_word
endmodule : sfc_host_model
`default_nettype wire

// ### sfc_counter_ctrl_test.sv
/*
 * Self-checking bench of the fastlock and counter-control bank.
 * Assumes the design files and sfc_params.svh are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sfc_params.svh"

module sfc_counter_ctrl_test;
  import sfc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, rf_cmp = 1'b0, if_cmp = 1'b0;
  logic strobe = 1'b0, pwr = 1'b0, wide = 1'b0;
  logic [11:0] den_lo = 12'h000;
  logic [9:0] den_hi = 10'h000;
  logic sclk, sdat, latch, pin_o, pin_oe_n, fl_act, ld_rf, ld_if;
  logic [21:0] den;
  logic [4:0] mult;
  logic [2:0] shift;
  sfc_pump_ctl_t pump;
  int num_errors = 0, cmp_count = 0, rf_n = 0, if_n = 0;

  // Design and host
  sfc_counter_ctrl i_sfc_counter_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk_link(sclk), .serial_data(sdat), .latch_en(latch),
    .rf_cmp_pin(rf_cmp), .if_cmp_pin(if_cmp), .freq_word_strobe(strobe),
    .power_up_pulse(pwr), .wide_fraction_sel(wide), .den_low(den_lo),
    .den_high(den_hi), .rf_fraction_denominator(den),
    .rf_fastlock_pin_o(pin_o), .rf_fastlock_pin_oe_n(pin_oe_n),
    .fastlock_active(fl_act), .rf_pump_mult(mult),
    .cycle_slip_shift(shift), .ld_rf_tick(ld_rf), .ld_if_tick(ld_if),
    .pump_ctl(pump));
  sfc_host_model i_sfc_host_model (.sclk_link(sclk), .serial_data(sdat),
    .latch_en(latch));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // Lock-detect tick counters
  always @(posedge sys_clk) begin
    if (ld_rf === 1'b1) rf_n++;
    if (ld_if === 1'b1) if_n++;
  end

  // *****************************************************************
  // Shared tasks
  // *****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic check(input string nm, input logic [21:0] e,
                       input logic [21:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check

  task automatic fl_word(input logic [1:0] c, input logic [3:0] p,
                         input logic [13:0] t);
    i_sfc_host_model.send_word({c, p, t, `SFC_ADDR_FASTLOCK});
    cyc(1);
  endtask : fl_word

  task automatic pulses(input int n);
    repeat (n) begin
      rf_cmp = 1'b1;
      if_cmp = 1'b1;
      cyc(2);
      rf_cmp = 1'b0;
      if_cmp = 1'b0;
      cyc(2);
    end
  endtask : pulses

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // *****************************************************************
  // Scenarios
  // *****************************************************************
  task automatic t_reset;
    check("pump after reset", 22'hF, 22'(pump));
    cyc(8);
    check("pump settled", 22'h0, 22'(pump));
    check("pin float", 22'h1, 22'(pin_oe_n));
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
    cyc(1);
    check("pump power-up", 22'hF, 22'(pump));
    cyc(8);
    check("pump after pulse", 22'h0, 22'(pump));
    $display("test reset done");
  endtask : t_reset

  task automatic t_den;
    den_lo = 12'hABC;
    den_hi = 10'h3FF;
    cyc(3);
    check("den narrow", 22'h000ABC, den);
    wide = 1'b1;
    den_lo = 12'hFFF;
    cyc(3);
    check("den wide", 22'h3FFFFF, den);
    $display("test denominator done");
  endtask : t_den

  task automatic t_modes;
    logic [2:0] exp [4] = '{3'b010, 3'b001, 3'b000, 3'b100};
    for (int m = 0; m < 4; m++) begin
      fl_word(2'h0, 4'h0, 14'(m));
      check("pin mode", 22'(exp[m]), {pin_o, pin_oe_n, fl_act});
      check("mode pump", 22'(m == 1), 22'(mult));
    end
    i_sfc_host_model.send_word({2'h0, 4'h0, 14'h0, 4'hE});
    cyc(1);
    check("unmapped word", 22'h4, {pin_o, pin_oe_n, fl_act});
    $display("test pin modes done");
  endtask : t_modes

  task automatic t_fast;
    logic [2:0] sh [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    for (int c = 0; c < 4; c++) begin
      fl_word(2'(c), 4'hF, 14'h0004);
      check("slip shift", 22'(sh[c]), 22'(shift));
    end
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    cyc(2);
    check("fastlock on", 22'h5, {pin_o, pin_oe_n, fl_act});
    check("pump mult", 22'h10, 22'(mult));
    pulses(7);
    check("still on", 22'h1, 22'(fl_act));
    pulses(1);
    cyc(6);
    check("fastlock off", 22'h0, {15'h0, pin_o, mult, fl_act});
    $display("test fastlock done");
  endtask : t_fast

  task automatic t_test_reg;
    logic [3:0] bits [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [3:0] exp [4] = '{4'h3, 4'hC, 4'h1, 4'h4};
    for (int b = 0; b < 4; b++) begin
      i_sfc_host_model.send_word({12'h000, 4'h8, bits[b], 4'hF});
      cyc(1);
      check("pump control", 22'(exp[b]), 22'(pump));
    end
    i_sfc_host_model.send_word({12'h002, 4'h8, 4'h0, 4'hF});
    cyc(1);
    check("pump released", 22'h0, 22'(pump));
    rf_n = 0;
    if_n = 0;
    pulses(8);
    cyc(6);
    check("rf ticks", 22'h2, 22'(rf_n));
    check("if ticks", 22'h8, 22'(if_n));
    $display("test counter control done");
  endtask : t_test_reg

  // Watchdog
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_den();
    t_modes();
    t_fast();
    t_test_reg();
    print_verdict();
  end
endmodule : sfc_counter_ctrl_test
`default_nettype wire
